// file: rtl/wcd_top.sv
// Wake-up card detection: register slave, scheduler, averaging, calibration
//
// The implementer's own choices: the register addresses and the Avalon-MM interface to the registers.
`include "wcd_consts.svh"
module wcd_top
  import wcd_pkg::*;
#(
  parameter int RC_DIV = `WCD_RC_DIV,
  parameter int TICKS_PER_MS = `WCD_RC_TICKS_PER_MS,
  parameter int FIELD_CYC = `WCD_FIELD_CYC,
  parameter logic [7:0] CAL_TARGET = `WCD_CAL_TARGET
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Avalon-MM slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Measurement front end
  output logic meas_start,
  output logic [1:0] meas_sel,
  input wire logic meas_done,
  input wire logic [7:0] meas_value,
  output logic reader_output_driver,
  output logic excitation_electrode,
  output logic [4:0] cal_code,
  // Host status
  output logic wakeup_active,
  output logic card_irq
);
  localparam int NM = 3;

  wcd_state_t state;
  logic [7:0] op_ctrl;
  logic [7:0] wut_ctrl;
  logic [7:0] cal_ctl;
  logic [7:0] conf [NM];
  logic [7:0] host_ref [NM];
  logic [7:0] result [NM];
  wcd_avg_t avg [NM];
  wcd_avg_t next_avg [NM];
  logic over [NM];
  logic seed [NM];
  logic irq_flag [NM];
  logic init_pend;
  logic cal_req;
  logic cal_mode;
  logic cal_done;
  logic cal_err;
  logic [2:0] cal_bit;
  logic [4:0] cal_work;
  logic [1:0] cur;
  logic [15:0] field_cnt;
  logic [15:0] fon_len;
  logic expire;

  logic [7:0] idx;
  logic wr_acc;
  logic set_def;
  logic wake_entry;
  logic [2:0] stat_clr;
  logic [2:0] en;
  logic [2:0] pk_first;
  logic [2:0] pk_next;
  logic [4:0] cal_mask;
  logic [4:0] next_cal_work;

  // Method group decode: {hit, method, slot}
  function automatic logic [4:0] meth_dec(input logic [7:0] i);
    logic [7:0] o;
    o = i - `WCD_IDX_METH0;
    return {(i >= `WCD_IDX_METH0) && (i <= `WCD_IDX_LAST), o[3:2], o[1:0]};
  endfunction

  // First enabled method after a given one, or at it when incl is set: {found, method}
  function automatic logic [2:0] pick(input logic [2:0] e, input logic [1:0] from,
                                      input logic incl);
    logic [2:0] r;
    r = 3'h0;
    for (int k = NM - 1; k >= 0; k--) begin
      if (e[k] && (incl ? (k >= int'(from)) : (k > int'(from)))) begin
        r = {1'b1, 2'(k)};
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] rd_reg(input logic [7:0] i);
    logic [4:0] d;
    logic [7:0] v;
    d = meth_dec(i);
    v = 8'h00;
    if (d[4]) begin
      case (d[1:0])
        2'h0: v = conf[d[3:2]];
        2'h1: v = host_ref[d[3:2]];
        2'h2: v = avg[d[3:2]][9:2];
        default: v = result[d[3:2]];
      endcase
    end else begin
      case (i)
        `WCD_IDX_OP: v = op_ctrl;
        `WCD_IDX_WUT: v = wut_ctrl;
        `WCD_IDX_CALCTL: v = cal_ctl;
        `WCD_IDX_CALDISP: v = {1'b0, cal_err, cal_done, cal_work};
        `WCD_IDX_STAT: v = {4'h0, wakeup_active, irq_flag[2], irq_flag[1], irq_flag[0]};
        default: v = 8'h00;
      endcase
    end
    return v;
  endfunction

  assign idx = {2'h0, address[7:2]};
  assign wr_acc = write && !waitrequest;
  assign set_def = wr_acc && (idx == `WCD_IDX_CMD) && writedata[`WCD_CMD_DEF_BIT];
  assign wake_entry = wr_acc && (idx == `WCD_IDX_OP) && (writedata[7:0] == `WCD_OP_WU) &&
                      !wakeup_active;
  assign stat_clr = (wr_acc && (idx == `WCD_IDX_STAT)) ? writedata[2:0] : 3'h0;
  assign en = wut_ctrl[`WCD_WUT_EN_LSB +: 3];
  assign pk_first = pick(en, 2'h0, 1'b1);
  assign pk_next = pick(en, cur, 1'b0);
  assign cal_mask = 5'(5'h01 << cal_bit);
  assign next_cal_work = (meas_value < CAL_TARGET) ? (cal_work & ~cal_mask) : cal_work;

  // Bus handshake: one wait cycle, then accept
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !(waitrequest && (read || write));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      readdata <= 32'h0000_0000;
    end else if (read && waitrequest) begin
      readdata <= {24'h00_0000, rd_reg(idx)};
    end
  end

  // Operation control and commands
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      op_ctrl <= 8'h00;
      wakeup_active <= 1'b0;
      init_pend <= 1'b1;
      cal_req <= 1'b0;
    end else begin
      if (wr_acc && (idx == `WCD_IDX_OP)) begin
        op_ctrl <= writedata[7:0];
        wakeup_active <= (writedata[7:0] == `WCD_OP_WU);
      end
      if (set_def) begin
        init_pend <= 1'b1;
      end else if (wake_entry) begin
        init_pend <= 1'b0;
      end
      if (wr_acc && (idx == `WCD_IDX_CMD) && writedata[`WCD_CMD_CAL_BIT] &&
          !wakeup_active) begin
        cal_req <= 1'b1;
      end else if (state == wcd_idle) begin
        cal_req <= 1'b0;
      end
    end
  end

  // Configuration, frozen in use by host discipline
  always_ff @(posedge ref_clk) begin
    if (!rstn || set_def) begin
      wut_ctrl <= `WCD_WUT_RST;
      cal_ctl <= 8'h00;
      for (int m = 0; m < NM; m++) begin
        conf[m] <= 8'h00;
        host_ref[m] <= 8'h00;
      end
    end else if (wr_acc) begin
      if (idx == `WCD_IDX_WUT) begin
        wut_ctrl <= writedata[7:0];
      end
      if (idx == `WCD_IDX_CALCTL) begin
        cal_ctl <= {3'h0, writedata[4:0]};
      end
      for (int m = 0; m < NM; m++) begin
        if (meth_dec(idx) == {1'b1, 2'(m), 2'h0}) begin
          conf[m] <= writedata[7:0];
        end
        if (meth_dec(idx) == {1'b1, 2'(m), 2'h1}) begin
          host_ref[m] <= writedata[7:0];
        end
      end
    end
  end

  wcd_wutimer #(
    .RC_DIV(RC_DIV),
    .TICKS_PER_MS(TICKS_PER_MS)
  ) u_timer (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .run(wakeup_active),
    .ival(wut_ctrl[2:0]),
    .expire(expire)
  );

  // Scheduler and calibration search
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state <= wcd_idle;
      cur <= 2'h0;
      meas_start <= 1'b0;
      meas_sel <= 2'h0;
      cal_mode <= 1'b0;
      cal_done <= 1'b0;
      cal_err <= 1'b0;
      cal_bit <= 3'h0;
      cal_work <= 5'h00;
    end else begin
      meas_start <= 1'b0;
      if (wr_acc && (idx == `WCD_IDX_CALCTL)) begin
        cal_done <= 1'b0;
      end
      unique case (state)
        wcd_idle: begin
          if (wakeup_active) begin
            state <= wcd_wait;
          end else if (cal_req) begin
            state <= wcd_cal;
            cal_mode <= 1'b1;
            cal_done <= 1'b0;
            cal_err <= 1'b0;
            cal_bit <= 3'h4;
            cal_work <= 5'h10;
          end
        end
        wcd_wait: begin
          if (!wakeup_active) begin
            state <= wcd_idle;
          end else if (expire && pk_first[2]) begin
            cur <= pk_first[1:0];
            meas_sel <= pk_first[1:0];
            meas_start <= 1'b1;
            state <= wcd_meas;
          end
        end
        wcd_meas: begin
          if (meas_done && cal_mode) begin
            cal_work <= next_cal_work;
            if (cal_bit == 3'h0) begin
              cal_mode <= 1'b0;
              cal_done <= 1'b1;
              cal_err <= (next_cal_work == 5'h00) || (next_cal_work == 5'h1f);
              state <= wcd_idle;
            end else begin
              cal_bit <= cal_bit - 3'h1;
              cal_work <= next_cal_work | 5'(cal_mask >> 1);
              state <= wcd_cal;
            end
          end else if (meas_done) begin
            state <= wcd_next;
          end
        end
        wcd_next: begin
          if (wakeup_active && pk_next[2]) begin
            cur <= pk_next[1:0];
            meas_sel <= pk_next[1:0];
            meas_start <= 1'b1;
            state <= wcd_meas;
          end else begin
            state <= wcd_wait;
          end
        end
        wcd_cal: begin
          meas_sel <= wcd_cap;
          meas_start <= 1'b1;
          state <= wcd_meas;
        end
        default: state <= wcd_idle;
      endcase
    end
  end

  // Reader field and excitation electrode drive
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      reader_output_driver <= 1'b0;
      excitation_electrode <= 1'b0;
      field_cnt <= 16'h0000;
    end else if (meas_start) begin
      reader_output_driver <= (meas_sel != wcd_cap);
      excitation_electrode <= (meas_sel == wcd_cap);
      field_cnt <= 16'h0000;
    end else begin
      if (reader_output_driver) begin
        field_cnt <= field_cnt + 16'h0001;
        if ((field_cnt == 16'(FIELD_CYC - 1)) || meas_done) begin
          reader_output_driver <= 1'b0;
        end
      end
      if (meas_done) begin
        excitation_electrode <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cal_code <= 5'h00;
    end else begin
      cal_code <= (cal_mode || cal_done) ? cal_work : cal_ctl[4:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      card_irq <= 1'b0;
    end else begin
      card_irq <= irq_flag[0] || irq_flag[1] || irq_flag[2];
    end
  end

  // Field-on length seen by the checks
  always_ff @(posedge ref_clk) begin
    if (!rstn || !reader_output_driver) begin
      fon_len <= 16'h0000;
    end else begin
      fon_len <= fon_len + 16'h0001;
    end
  end

  default clocking dcb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  bus_answer_a: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  wake_enter_a: assert property (
    wr_acc && (idx == `WCD_IDX_OP) && (writedata[7:0] == `WCD_OP_WU) |=> wakeup_active)
    else $error("wake-up request not taken");
  wake_block_a: assert property (
    wr_acc && (idx == `WCD_IDX_OP) && (writedata[7:0] != `WCD_OP_WU) |=> !wakeup_active)
    else $error("wake-up mode entered with other bits set");
  sched_run_a: assert property (
    (state == wcd_wait) && wakeup_active && expire && (en != 3'h0)
    |=> meas_start && en[meas_sel])
    else $error("timer expiry did not start an enabled method");
  field_time_a: assert property (fon_len <= 16'(FIELD_CYC))
    else $error("reader field on too long");
  cal_finish_a: assert property (
    (state == wcd_meas) && meas_done && cal_mode && (cal_bit == 3'h0)
    |=> cal_done && !cal_mode ##1 (cal_code == $past(cal_work)))
    else $error("calibration result not stored");

  for (genvar m = 0; m < NM; m++) begin : g_meth
    logic samp;
    logic hit;
    assign samp = (state == wcd_meas) && meas_done && !cal_mode && (cur == 2'(m));
    assign hit = samp && over[m] && !(conf[m][`WCD_CONF_AUTO_BIT] && seed[m]);

    wcd_avg u_avg (
      .conf(conf[m]),
      .host_ref(host_ref[m]),
      .avg(avg[m]),
      .meas(meas_value),
      .next_avg(next_avg[m]),
      .over(over[m])
    );

    always_ff @(posedge ref_clk) begin
      if (!rstn) begin
        avg[m] <= 10'h000;
        seed[m] <= 1'b0;
      end else if (wake_entry && init_pend) begin
        if (host_ref[m] != 8'h00) begin
          avg[m] <= {host_ref[m], 2'h0};
          seed[m] <= 1'b0;
        end else begin
          seed[m] <= 1'b1;
        end
      end else if (samp && conf[m][`WCD_CONF_AUTO_BIT]) begin
        if (seed[m]) begin
          avg[m] <= {meas_value, 2'h0};
          seed[m] <= 1'b0;
        end else if (!over[m] || conf[m][`WCD_CONF_AAM_BIT]) begin
          avg[m] <= next_avg[m];
        end
      end
    end

    always_ff @(posedge ref_clk) begin
      if (!rstn) begin
        result[m] <= 8'h00;
      end else if (samp) begin
        result[m] <= meas_value;
      end
    end

    // Set wins over a same-cycle clear
    always_ff @(posedge ref_clk) begin
      if (!rstn) begin
        irq_flag[m] <= 1'b0;
      end else if (hit) begin
        irq_flag[m] <= 1'b1;
      end else if (stat_clr[m]) begin
        irq_flag[m] <= 1'b0;
      end
    end

    irq_set_a: assert property (hit |=> irq_flag[m] ##1 card_irq)
      else $error("threshold excess did not raise interrupt");
    avg_step_a: assert property (
      samp && conf[m][`WCD_CONF_AUTO_BIT] && !seed[m] && !over[m]
      |=> avg[m] == $past(next_avg[m]))
      else $error("average not updated");
    avg_skip_a: assert property (
      samp && over[m] && !conf[m][`WCD_CONF_AAM_BIT] && !seed[m] &&
      !(wake_entry && init_pend)
      |=> $stable(avg[m]))
      else $error("interrupting sample entered the average");
    init_seed_a: assert property (
      wake_entry && !init_pend && !samp |=> $stable(avg[m]) && $stable(seed[m]))
      else $error("averaging re-initialised on a later entry");
  end
endmodule

// file: rtl/wcd_consts.svh
// Register map, field positions, reset values and timing counts
`ifndef WCD_CONSTS_SVH
`define WCD_CONSTS_SVH
// Register indexes; byte address is four times the index
`define WCD_IDX_CMD 8'h01
`define WCD_IDX_OP 8'h02
`define WCD_IDX_STAT 8'h1a
`define WCD_IDX_CALCTL 8'h2e
`define WCD_IDX_CALDISP 8'h2f
`define WCD_IDX_WUT 8'h32
`define WCD_IDX_METH0 8'h33
`define WCD_IDX_LAST 8'h3e
// Field positions and values
`define WCD_OP_WU 8'h04
`define WCD_CMD_DEF_BIT 0
`define WCD_CMD_CAL_BIT 1
`define WCD_WUT_EN_LSB 3
`define WCD_CONF_WGT_LSB 4
`define WCD_CONF_AUTO_BIT 6
`define WCD_CONF_AAM_BIT 7
// Reset values
`define WCD_WUT_RST 8'h03
`define WCD_CAL_TARGET 8'h80
// Timing
`define WCD_CLK_HZ 20000000
`define WCD_CLK_NS 50
`define WCD_RC_HZ 32000
`define WCD_RC_DIV (`WCD_CLK_HZ / `WCD_RC_HZ)
`define WCD_RC_TICKS_PER_MS (`WCD_RC_HZ / 1000)
`define WCD_FIELD_NS 20000
`define WCD_FIELD_CYC (`WCD_FIELD_NS / `WCD_CLK_NS)
`define WCD_WU_MS0 10
`define WCD_WU_MS1 20
`define WCD_WU_MS2 50
`define WCD_WU_MS3 100
`define WCD_WU_MS4 200
`define WCD_WU_MS5 400
`define WCD_WU_MS6 600
`define WCD_WU_MS7 800
`endif

// file: rtl/wcd_pkg.sv
// Types shared by the card detection block
package wcd_pkg;
  typedef enum logic [2:0] {
    wcd_idle = 3'h0,
    wcd_wait = 3'h1,
    wcd_meas = 3'h3,
    wcd_next = 3'h2,
    wcd_cal = 3'h6
  } wcd_state_t;
  typedef enum logic [1:0] {
    wcd_amp = 2'h0,
    wcd_phase = 2'h1,
    wcd_cap = 2'h2
  } wcd_meth_t;
  typedef logic [9:0] wcd_avg_t;
endpackage

// file: rtl/wcd_wutimer.sv
// Wake-up timer on a divided low-power tick
`include "wcd_consts.svh"
module wcd_wutimer #(
  parameter int RC_DIV = `WCD_RC_DIV,
  parameter int TICKS_PER_MS = `WCD_RC_TICKS_PER_MS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Control
  input wire logic run,
  input wire logic [2:0] ival,
  // Expiry pulse
  output logic expire
);
  logic [15:0] div_cnt;
  logic rc_tick;
  logic [15:0] tk_cnt;

  function automatic logic [15:0] ival_ticks(input logic [2:0] c);
    int ms;
    ms = 0;
    case (c)
      3'h0: ms = `WCD_WU_MS0;
      3'h1: ms = `WCD_WU_MS1;
      3'h2: ms = `WCD_WU_MS2;
      3'h3: ms = `WCD_WU_MS3;
      3'h4: ms = `WCD_WU_MS4;
      3'h5: ms = `WCD_WU_MS5;
      3'h6: ms = `WCD_WU_MS6;
      default: ms = `WCD_WU_MS7;
    endcase
    return 16'(ms * TICKS_PER_MS);
  endfunction

  // Stand-in for the 32 kHz oscillator
  always_ff @(posedge ref_clk) begin
    if (!rstn || !run) begin
      div_cnt <= 16'h0000;
      rc_tick <= 1'b0;
    end else if (div_cnt == 16'(RC_DIV - 1)) begin
      div_cnt <= 16'h0000;
      rc_tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
      rc_tick <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn || !run) begin
      tk_cnt <= 16'h0000;
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (rc_tick) begin
        if (tk_cnt >= ival_ticks(ival) - 16'h0001) begin
          tk_cnt <= 16'h0000;
          expire <= 1'b1;
        end else begin
          tk_cnt <= tk_cnt + 16'h0001;
        end
      end
    end
  end
endmodule

// file: rtl/wcd_avg.sv
// Reference selection, threshold compare and averaging step
`include "wcd_consts.svh"
module wcd_avg
  import wcd_pkg::*;
(
  // Method configuration
  input wire logic [7:0] conf,
  input wire logic [7:0] host_ref,
  // Averager state and sample
  input wire wcd_avg_t avg,
  input wire logic [7:0] meas,
  // Results
  output wcd_avg_t next_avg,
  output logic over
);
  logic signed [11:0] diff;
  logic signed [11:0] step;
  logic [7:0] ref_v;
  logic [7:0] mag;
  logic [1:0] wgt;

  always_comb begin
    wgt = conf[`WCD_CONF_WGT_LSB +: 2];
    diff = $signed({2'h0, avg}) - $signed({2'h0, meas, 2'h0});
    step = diff >>> wgt;
    next_avg = 10'($signed({2'h0, avg}) - step);
    ref_v = conf[`WCD_CONF_AUTO_BIT] ? avg[9:2] : host_ref;
    mag = (meas > ref_v) ? meas - ref_v : ref_v - meas;
    over = mag > {4'h0, conf[3:0]};
  end
endmodule

// file: sim/wcd_fe_model.sv
// Measurement front end model answering start pulses
module wcd_fe_model (
  // Clock
  input wire logic ref_clk,
  // Measurement link
  input wire logic meas_start,
  input wire logic [1:0] meas_sel,
  output logic meas_done = 1'b0,
  output logic [7:0] meas_value = 8'h5a,
  input wire logic reader_output_driver,
  input wire logic excitation_electrode,
  input wire logic [4:0] cal_code,
  // Bench controls
  input wire logic [7:0] amp_val,
  input wire logic [7:0] phase_val,
  input wire logic [7:0] lat,
  output logic [7:0] n_done = 8'h00,
  output logic field_seen = 1'b0,
  output logic exc_seen = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic busy = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [7:0] cnt = 8'h00;
  always @(posedge ref_clk) begin
    meas_done <= 1'b0;
    // Result line toggles when no result is valid
    meas_value <= ~meas_value;
    if (meas_start) begin
      busy <= 1'b1;
      sel <= meas_sel;
      cnt <= lat;
    end else if (busy) begin
      if (reader_output_driver && sel != 2'h2) begin
        field_seen <= 1'b1;
      end
      if (excitation_electrode && sel == 2'h2) begin
        exc_seen <= 1'b1;
      end
      if (cnt > 8'h01) begin
        cnt <= cnt - 8'h01;
      end else begin
        busy <= 1'b0;
        meas_done <= 1'b1;
        n_done <= n_done + 8'h01;
        // Capacitive result falls as the calibration code rises
        meas_value <= (sel == 2'h0) ? amp_val : (sel == 2'h1) ? phase_val :
          8'hff - {cal_code, 3'h0};
      end
    end
  end
endmodule

// file: sim/testbench.sv
// Self-checking bench for the wake-up card detection block
`include "wcd_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest, meas_start, meas_done, reader_output_driver, excitation_electrode;
  logic [1:0] meas_sel;
  logic [7:0] meas_value, n_done;
  logic [4:0] cal_code;
  logic wakeup_active, card_irq, field_seen, exc_seen;
  logic [7:0] amp_val = 8'h00;
  logic [7:0] phase_val = 8'h00;
  logic [7:0] lat = 8'h03;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  always #25 ref_clk = ~ref_clk;
  wcd_top #(.RC_DIV(2), .TICKS_PER_MS(1)) i_dut (.ref_clk(ref_clk), .rstn(rstn),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .meas_start(meas_start),
    .meas_sel(meas_sel), .meas_done(meas_done), .meas_value(meas_value),
    .reader_output_driver(reader_output_driver), .excitation_electrode(excitation_electrode),
    .cal_code(cal_code), .wakeup_active(wakeup_active), .card_irq(card_irq));
  wcd_fe_model i_fe (.ref_clk(ref_clk), .meas_start(meas_start), .meas_sel(meas_sel),
    .meas_done(meas_done), .meas_value(meas_value),
    .reader_output_driver(reader_output_driver), .cal_code(cal_code), .amp_val(amp_val),
    .phase_val(phase_val), .lat(lat), .n_done(n_done), .field_seen(field_seen),
    .excitation_electrode(excitation_electrode), .exc_seen(exc_seen));
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
    output logic [7:0] rd);
    @(posedge ref_clk);
    address <= {idx[5:0], 2'b00};
    read <= ~wr;
    write <= wr;
    writedata <= {24'h0, wd};
    do begin
      @(posedge ref_clk);
    end while (waitrequest !== 1'b0);
    rd = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] x;
    bus(1'b1, idx, d, x);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] x;
    bus(1'b0, idx, 8'h00, x);
    chk(nm, exp, x);
  endtask
  task automatic settle();
    repeat (3) @(negedge ref_clk);
  endtask
  task automatic wait_done(input int k);
    int t0;
    t0 = n_done;
    wait (n_done >= t0 + k);
    settle();
  endtask
  task automatic t_reset();
    rd_chk("wut", `WCD_IDX_WUT, `WCD_WUT_RST);
    rd_chk("unmapped", 8'h3f, 8'h00);
    chk("active", 8'h00, {7'h0, wakeup_active});
    $display("test reset done");
  endtask
  task automatic t_entry();
    wr(`WCD_IDX_OP, 8'h05);
    settle();
    chk("active extra bit", 8'h00, {7'h0, wakeup_active});
    wr(`WCD_IDX_OP, `WCD_OP_WU);
    settle();
    chk("active", 8'h01, {7'h0, wakeup_active});
    wr(`WCD_IDX_OP, 8'h00);
    settle();
    chk("left", 8'h00, {7'h0, wakeup_active});
    $display("test entry done");
  endtask
  task automatic t_hostref();
    wr(`WCD_IDX_WUT, 8'h18);
    wr(8'h33, 8'h04);
    wr(8'h34, 8'h64);
    wr(8'h37, 8'h0f);
    wr(8'h38, 8'h30);
    amp_val <= 8'h6e;
    phase_val <= 8'h33;
    wr(`WCD_IDX_OP, `WCD_OP_WU);
    wait_done(2);
    chk("card_irq", 8'h01, {7'h0, card_irq});
    rd_chk("stat", `WCD_IDX_STAT, 8'h09);
    rd_chk("amp last", 8'h36, 8'h6e);
    rd_chk("phase order", 8'h3a, 8'h33);
    chk("field", 8'h01, {7'h0, field_seen});
    wr(`WCD_IDX_OP, 8'h00);
    repeat (40) @(posedge ref_clk);
    wr(`WCD_IDX_STAT, 8'h07);
    rd_chk("stat clr", `WCD_IDX_STAT, 8'h00);
    $display("test hostref done");
  endtask
  task automatic t_auto();
    wr(`WCD_IDX_CMD, 8'h01);
    rd_chk("wut dflt", `WCD_IDX_WUT, 8'h03);
    wr(`WCD_IDX_WUT, 8'h10);
    wr(8'h37, 8'h5f);
    phase_val <= 8'h50;
    wr(`WCD_IDX_OP, `WCD_OP_WU);
    wait_done(1);
    phase_val <= 8'h58;
    rd_chk("seed", 8'h39, 8'h50);
    wait_done(1);
    rd_chk("no irq", `WCD_IDX_STAT, 8'h08);
    phase_val <= 8'h90;
    wait_done(1);
    wr(`WCD_IDX_OP, 8'h00);
    rd_chk("avg", 8'h39, 8'h54);
    rd_chk("phase last", 8'h3a, 8'h90);
    rd_chk("irq auto", `WCD_IDX_STAT, 8'h02);
    $display("test auto done");
  endtask
  task automatic t_cal();
    lat <= 8'h28;
    wr(`WCD_IDX_CMD, 8'h02);
    wait_done(5);
    rd_chk("caldisp", `WCD_IDX_CALDISP, 8'h2f);
    chk("cal auto", 8'h0f, {3'h0, cal_code});
    chk("excite", 8'h01, {7'h0, exc_seen});
    wr(`WCD_IDX_CALCTL, 8'h07);
    settle();
    chk("cal man", 8'h07, {3'h0, cal_code});
    $display("test cal done");
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    t_reset();
    t_entry();
    t_hostref();
    t_auto();
    t_cal();
    close_out();
  end
endmodule
